/* hw/pob_output_stage.v */
// pwm output stage: masking, fault brake, polarity and period event flag
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`include "pob_defines.vh"

// What this block does
// [RULE1] per-channel mask enable picks generator or mask level; enables reset to zero
// [RULE2] masked channel is driven low for mask level 0, high for 1
// [RULE3] masked level still passes through that channel's polarity inversion
// [RULE4] brake pin acts only while pin-brake enable bit 3 of control second is set
// [RULE5] during brake channels 0..5 take their brake data bit
// [RULE6] a brake event clears the run bit, bit 7 of control 0
// [RULE7] a brake event resets the 16-bit period counter to zero
// [RULE8] a brake event sets brake flag bit 7, which requests the brake interrupt
// [RULE9] software clears the brake flag; clearing it does not release the brake
// [RULE10] setting the run bit again releases the brake and normal waveforms return
// [RULE11] edge select bit 6: 0 falling edge, 1 rising edge triggers a brake
// [RULE12] brake pin always filtered by an eight-clock debounce
// [RULE13] fault source holds its level more than eight clocks
// [RULE14] adc compare event triggers the same full brake behaviour
// [RULE15] polarity bit 0 drives pin directly, 1 inverts; resets to 0
// [RULE16] event flag bit 5 of control 0 set at the selected period point
// [RULE17] centre and end events only occur in center-aligned operation
// [RULE18] software clears the event flag itself
// [RULE19] event type 00 fall, 01 rise, 10 centre, 11 end of period
// [RULE20] channel select 000..101 picks channel 0..5, other codes channel 0
// [RULE21] brake interrupt has its own output and its own enable bit
// [RULE22] path order: generator, mask, brake override, polarity, pin
// [RULE23] brake reacts to a debounced edge, one clock after filter accepts it
module pob_output_stage
(
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // apb slave
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  // from the rest of the pwm unit
  input  wire [5:0]  gen_in,
  input  wire        period_center_in,
  input  wire        period_end_in,
  input  wire        adc_cmp_event_in,
  // fault brake pin
  input  wire        brake_pin_in,
  // to the rest of the pwm unit
  output wire        run_out,
  output wire        counter_clear_out,
  output wire [7:0]  ctrl_second_out,
  output wire [7:0]  event_ctrl_out,
  // interrupts, separate lines
  output wire        brake_irq_out,
  output wire        event_irq_out,
  // output pins
  output wire [5:0]  pwm_out
);

  // ==========================================================
  // state machine and helpers
  // ==========================================================
  localparam ST_RUN   = 2'b01;
  localparam ST_BRAKE = 2'b10;

  // word hit at a register index, byte address is index times four
  function hit;
    input [11:0] addr;
    input [9:0]  idx;
    begin
      hit = (addr == {idx, 2'b00});
    end
  endfunction

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [5:0]  invert_reg;
  reg  [7:0]  brake_reg;
  reg  [7:0]  brake_next;
  reg  [7:0]  ctrl1_reg;
  reg  [5:0]  mask_en_reg;
  reg  [5:0]  mask_lvl_reg;
  reg  [7:0]  evt_ctrl_reg;
  reg  [7:0]  ctrl0_reg;
  reg  [7:0]  ctrl0_next;
  reg  [1:0]  irq_en_reg;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg  [2:0]  deb_cnt_reg;
  reg         deb_filt_reg;
  reg         deb_prev_reg;
  reg  [5:0]  gen_prev_reg;
  reg         clear_reg;
  reg         brake_irq_reg;
  reg         event_irq_reg;
  reg  [5:0]  pwm_reg;
  reg  [5:0]  pin_next;
  reg  [7:0]  rd_byte;
  reg         rd_ok;
  reg         evt_hit;
  reg  [2:0]  ch_sel;
  wire        wr_en;
  wire        pin_edge;
  wire        brake_event;

  // ==========================================================
  // apb slave
  // ==========================================================
  // writes land only on the access cycle that sees pready high
  assign wr_en = psel_in & penable_in & pready_reg & pwrite_in
                 & ~pslverr_reg;

  // read mux, evaluated in the setup cycle
  always @*
  begin
    rd_ok   = 1'b1;
    rd_byte = `POB_RST_BYTE;
    if (paddr_in[1:0] != 2'b00)
      rd_ok = 1'b0;
    else if (hit(paddr_in, `POB_IDX_INVERT))
      rd_byte = {2'b00, invert_reg};
    else if (hit(paddr_in, `POB_IDX_BRAKE))
      rd_byte = brake_reg;
    else if (hit(paddr_in, `POB_IDX_CTRL1))
      rd_byte = ctrl1_reg;
    else if (hit(paddr_in, `POB_IDX_MASK_EN))
      rd_byte = {2'b00, mask_en_reg};
    else if (hit(paddr_in, `POB_IDX_MASK_LVL))
      rd_byte = {2'b00, mask_lvl_reg};
    else if (hit(paddr_in, `POB_IDX_EVT_CTRL))
      rd_byte = evt_ctrl_reg & `POB_MASK_EVT_CTRL;
    else if (hit(paddr_in, `POB_IDX_CTRL0))
      rd_byte = ctrl0_reg;
    else if (hit(paddr_in, `POB_IDX_IRQ_EN))
      rd_byte = {6'h00, irq_en_reg};
    else
      rd_ok = 1'b0;
  end

  // no wait state: answer registered from the setup cycle
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= psel_in & ~penable_in;
      if (psel_in & ~penable_in)
      begin
        prdata_reg  <= {24'h000000, rd_byte};
        pslverr_reg <= ~rd_ok;
      end
      else if (~psel_in)
        pslverr_reg <= 1'b0;
    end
  end

  // ==========================================================
  // brake pin debounce and edge detect
  // ==========================================================
  // level accepted only after eight clocks of disagreement
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      deb_cnt_reg  <= `POB_DEB_ZERO;
      deb_filt_reg <= 1'b0;
      deb_prev_reg <= 1'b0;
    end
    else
    begin
      deb_prev_reg <= deb_filt_reg;
      if (brake_pin_in == deb_filt_reg)
        deb_cnt_reg <= `POB_DEB_ZERO; // [RULE12]
      else if (deb_cnt_reg == `POB_DEB_LAST)
      begin
        deb_filt_reg <= brake_pin_in; // [RULE12]
        deb_cnt_reg  <= `POB_DEB_ZERO;
      end
      else
        deb_cnt_reg <= deb_cnt_reg + `POB_DEB_ONE;
    end
  end

  // edge on the filtered level, polarity from edge select
  assign pin_edge = brake_reg[`POB_BRK_EDGE] ?
                    (deb_filt_reg & ~deb_prev_reg) :
                    (~deb_filt_reg & deb_prev_reg); // [RULE11] [RULE23]

  assign brake_event = (ctrl1_reg[`POB_CTRL1_PINEN] & pin_edge) // [RULE4]
                       | adc_cmp_event_in; // [RULE14]

  // ==========================================================
  // period event detection
  // ==========================================================
  // a stale selection code falls back to channel zero
  always @*
  begin
    ch_sel = (evt_ctrl_reg[`POB_EVT_SEL_HI:0] > `POB_CH_LAST) ?
             `POB_CH_FIRST : evt_ctrl_reg[`POB_EVT_SEL_HI:0]; // [RULE20]
    evt_hit = 1'b0;
    case (evt_ctrl_reg[`POB_EVT_TYP_HI:`POB_EVT_TYP_LO]) // [RULE19]
      `POB_EVT_FALL:
        evt_hit = gen_prev_reg[ch_sel] & ~gen_in[ch_sel];
      `POB_EVT_RISE:
        evt_hit = ~gen_prev_reg[ch_sel] & gen_in[ch_sel];
      `POB_EVT_CENTER:
        evt_hit = period_center_in &
                  ctrl1_reg[`POB_CTRL1_CENTER]; // [RULE17]
      default:
        evt_hit = period_end_in &
                  ctrl1_reg[`POB_CTRL1_CENTER]; // [RULE17]
    endcase
  end

  // ==========================================================
  // brake state machine
  // ==========================================================
  // a new event in the same cycle as a run write keeps the brake
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN:
        if (brake_event)
          state_next = ST_BRAKE;
      ST_BRAKE:
        if (~brake_event & wr_en & hit(paddr_in, `POB_IDX_CTRL0)
            & pwdata_in[`POB_CTRL0_RUN])
          state_next = ST_RUN; // [RULE10]
      default:
        state_next = ST_RUN;
    endcase
  end

  // ==========================================================
  // control 0 and brake data next values, hardware beats software writes
  // ==========================================================
  always @*
  begin
    ctrl0_next = ctrl0_reg;
    if (wr_en & hit(paddr_in, `POB_IDX_CTRL0))
      ctrl0_next = pwdata_in[7:0]; // [RULE18]
    if (evt_hit)
      ctrl0_next[`POB_CTRL0_EVT] = 1'b1; // [RULE16]
    if (brake_event)
      ctrl0_next[`POB_CTRL0_RUN] = 1'b0; // [RULE6]
    brake_next = brake_reg;
    if (wr_en & hit(paddr_in, `POB_IDX_BRAKE))
      brake_next = pwdata_in[7:0]; // [RULE9]
    if (brake_event)
      brake_next[`POB_BRK_FLAG] = 1'b1; // [RULE8]
  end

  // ==========================================================
  // register file
  // ==========================================================
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_reg    <= ST_RUN;
      invert_reg   <= `POB_RST_CH;
      brake_reg    <= `POB_RST_BYTE;
      ctrl1_reg    <= `POB_RST_BYTE;
      mask_en_reg  <= `POB_RST_CH; // [RULE1]
      mask_lvl_reg <= `POB_RST_CH;
      evt_ctrl_reg <= `POB_RST_BYTE;
      ctrl0_reg    <= `POB_RST_BYTE;
      irq_en_reg   <= 2'b00;
    end
    else
    begin
      state_reg <= state_next;
      brake_reg <= brake_next;
      ctrl0_reg <= ctrl0_next;
      if (wr_en & hit(paddr_in, `POB_IDX_INVERT))
        invert_reg <= pwdata_in[5:0]; // [RULE15]
      if (wr_en & hit(paddr_in, `POB_IDX_CTRL1))
        ctrl1_reg <= pwdata_in[7:0];
      if (wr_en & hit(paddr_in, `POB_IDX_MASK_EN))
        mask_en_reg <= pwdata_in[5:0];
      if (wr_en & hit(paddr_in, `POB_IDX_MASK_LVL))
        mask_lvl_reg <= pwdata_in[5:0];
      if (wr_en & hit(paddr_in, `POB_IDX_EVT_CTRL))
        evt_ctrl_reg <= pwdata_in[7:0] & `POB_MASK_EVT_CTRL;
      if (wr_en & hit(paddr_in, `POB_IDX_IRQ_EN))
        irq_en_reg <= pwdata_in[1:0];
    end
  end

  // ==========================================================
  // output path
  // ==========================================================
  // stage order keeps brake levels in positive logic like masks
  always @*
  begin
    pin_next = (gen_in & ~mask_en_reg)
               | (mask_lvl_reg & mask_en_reg); // [RULE1] [RULE2]
    if (state_next == ST_BRAKE)
      pin_next = brake_next[5:0]; // [RULE5] [RULE22]
    pin_next = pin_next ^ invert_reg; // [RULE3] [RULE15]
  end

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      gen_prev_reg  <= `POB_RST_CH;
      clear_reg     <= 1'b0;
      brake_irq_reg <= 1'b0;
      event_irq_reg <= 1'b0;
      pwm_reg       <= `POB_RST_CH;
    end
    else
    begin
      gen_prev_reg  <= gen_in;
      clear_reg     <= brake_event; // [RULE7]
      brake_irq_reg <= brake_next[`POB_BRK_FLAG]
                       & irq_en_reg[`POB_IRQ_BRK_EN]; // [RULE21]
      event_irq_reg <= ctrl0_next[`POB_CTRL0_EVT]
                       & irq_en_reg[`POB_IRQ_EVT_EN];
      pwm_reg       <= pin_next;
    end
  end

  assign prdata_out        = prdata_reg;
  assign pready_out        = pready_reg;
  assign pslverr_out       = pslverr_reg;
  assign run_out           = ctrl0_reg[`POB_CTRL0_RUN];
  assign counter_clear_out = clear_reg;
  assign ctrl_second_out   = ctrl1_reg;
  assign event_ctrl_out    = evt_ctrl_reg;
  assign brake_irq_out     = brake_irq_reg;
  assign event_irq_out     = event_irq_reg;
  assign pwm_out           = pwm_reg;

endmodule // pob_output_stage

/* include/pob_defines.vh */
// constants for the pwm output stage with fault brake
`ifndef POB_DEFINES_VH
`define POB_DEFINES_VH

// register indices; byte address is four times the index
`define POB_IDX_INVERT     10'h0D6
`define POB_IDX_BRAKE      10'h0D7
`define POB_IDX_CTRL1      10'h0DF
`define POB_IDX_MASK_EN    10'h0FB
`define POB_IDX_MASK_LVL   10'h0FC
`define POB_IDX_EVT_CTRL   10'h0B7
`define POB_IDX_CTRL0      10'h0E1
`define POB_IDX_IRQ_EN     10'h0E2

// reset value shared by every register except the brake state, which resets to ST_RUN
`define POB_RST_BYTE       8'h00
`define POB_RST_CH         6'h00

// field positions
`define POB_CTRL0_RUN      7
`define POB_CTRL0_EVT      5
`define POB_CTRL1_PINEN    3
`define POB_CTRL1_CENTER   4
`define POB_BRK_FLAG       7
`define POB_BRK_EDGE       6
`define POB_IRQ_BRK_EN     0
`define POB_IRQ_EVT_EN     1

// field masks for readback
`define POB_MASK_CH        8'h3F
`define POB_MASK_EVT_CTRL  8'h37
`define POB_MASK_IRQ       8'h03

// event type codes
`define POB_EVT_FALL       2'h0
`define POB_EVT_RISE       2'h1
`define POB_EVT_CENTER     2'h2
`define POB_EVT_END        2'h3
`define POB_CH_LAST        3'h5
`define POB_CH_FIRST       3'h0
`define POB_EVT_TYP_HI     5
`define POB_EVT_TYP_LO     4
`define POB_EVT_SEL_HI     2

// debounce: brake pin must differ for 8 clocks, count 0..7
`define POB_DEB_LAST       3'h7
`define POB_DEB_ZERO       3'h0
`define POB_DEB_ONE        3'h1

`endif

/* tb/pob_output_stage_sva.sv */
// port checker for the pwm output stage
`timescale 1ns/1ps
module pob_output_stage_chk
(
  // clock and reset
  input wire        clk_in,
  input wire        rst_in,
  // apb
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out,
  // brake sources and results
  input wire        adc_cmp_event_in,
  input wire        brake_pin_in,
  input wire        run_out,
  input wire        counter_clear_out,
  input wire        brake_irq_out,
  input wire [5:0]  pwm_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  reg [3:0] stab_cnt;
  reg       last_pin;
  reg       brk_seen;
  // pin stability count and brake-held tracker
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stab_cnt <= 4'h0;
      last_pin <= 1'b0;
      brk_seen <= 1'b0;
    end
    else
    begin
      last_pin <= brake_pin_in;
      if (brake_pin_in != last_pin)
        stab_cnt <= 4'h0;
      else if (stab_cnt != 4'hF)
        stab_cnt <= stab_cnt + 4'h1;
      brk_seen <= run_out ? 1'b0 : (brk_seen | counter_clear_out);
    end
  end
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_quiet;
    !$past(psel_in) && !$past(psel_in, 2);
  endsequence
  chk_ready_time: assert property (s_setup |=> pready_out)
    else $error("pready late");
  chk_ready_one: assert property (pready_out |=> !pready_out)
    else $error("pready too long");
  chk_err_zero: assert property (pready_out && pslverr_out |-> prdata_out == 0)
    else $error("refused read not zero");
  chk_adc_brake: assert property (adc_cmp_event_in |=>
    !run_out && counter_clear_out) else $error("adc brake missing");
  chk_pin_filter: assert property (counter_clear_out &&
    !$past(adc_cmp_event_in) |-> stab_cnt >= 4'h7)
    else $error("brake on short pulse");
  chk_brake_hold: assert property (brk_seen && !run_out ##0 s_quiet
    |-> $stable(pwm_out)) else $error("brake levels moved");
  chk_run_soft: assert property ($rose(run_out) |->
    $past(psel_in && penable_in && pwrite_in)) else $error("run self set");
  chk_irq_cause: assert property ($rose(brake_irq_out) ##0 s_quiet |->
    counter_clear_out || $past(counter_clear_out))
    else $error("brake irq no cause");
endmodule // pob_output_stage_chk
bind pob_output_stage pob_output_stage_chk pob_output_stage_chk_i (
  .clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in),
  .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .adc_cmp_event_in(adc_cmp_event_in),
  .brake_pin_in(brake_pin_in), .run_out(run_out),
  .counter_clear_out(counter_clear_out),
  .brake_irq_out(brake_irq_out), .pwm_out(pwm_out));

/* tb/pob_gate_model.sv */
// gate driver side model driving the fault line away from its idle level
`timescale 1ns/1ps
module pob_gate_model
(
  // clock and reset
  input  wire clk_in,
  input  wire rst_in,
  // commands from the bench
  input  wire trip_in,
  input  wire glitch_in,
  input  wire idle_in,
  // fault line
  output wire fault_out
);
  reg [3:0] cnt_reg;
  // real faults are held well past the filter; noise is short
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_reg <= 4'h0;
    else if (trip_in)
      cnt_reg <= 4'hC;
    else if (glitch_in)
      cnt_reg <= 4'h4;
    else if (cnt_reg != 4'h0)
      cnt_reg <= cnt_reg - 4'h1;
  end
  assign fault_out = (cnt_reg != 4'h0) ? ~idle_in : idle_in;
endmodule // pob_gate_model

/* tb/pob_output_stage_tb.sv */
// register-level bench for the pwm output stage
`timescale 1ns/1ps
`include "pob_defines.vh"
module pob_output_stage_tb;
  reg clk_in, rst_in, psel_in, penable_in, pwrite_in;
  reg [11:0] paddr_in;
  reg [31:0] pwdata_in;
  wire [31:0] prdata_out;
  wire pready_out, pslverr_out, run_out, brake_irq_out, pin;
  wire [5:0] pwm_out;
  reg [5:0] gen_in;
  reg cen, adc, trip, glt, idle, err;
  reg [7:0] q;
  reg pend;
  wire clr, eirq;
  wire [7:0] c2, ec;
  integer fail_count, n_tests, k;
  pob_output_stage pob_output_stage_i (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .gen_in(gen_in),
    .period_center_in(cen), .period_end_in(pend),
    .adc_cmp_event_in(adc), .brake_pin_in(pin), .run_out(run_out),
    .counter_clear_out(clr), .ctrl_second_out(c2), .event_ctrl_out(ec),
    .brake_irq_out(brake_irq_out), .event_irq_out(eirq),
    .pwm_out(pwm_out));
  pob_gate_model pob_gate_model_i (.clk_in(clk_in), .rst_in(rst_in),
    .trip_in(trip), .glitch_in(glt), .idle_in(idle), .fault_out(pin));
  // one apb transfer; idle cycle after keeps strobes single-assigned
  task apb(input [9:0] i, input w, input [7:0] d);
    begin
      psel_in <= 1'b1; pwrite_in <= w; paddr_in <= {i, 2'h0};
      pwdata_in <= {24'h0, d};
      @(posedge clk_in) penable_in <= 1'b1;
      // wait for the answer; only the watchdog ends a hang
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      q = prdata_out[7:0]; err = pslverr_out;
      psel_in <= 1'b0; penable_in <= 1'b0;
      @(posedge clk_in);
    end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e)
      begin
        $display("unexpected %0s exp %h got %h", nm, e, g);
        fail_count = fail_count + 1;
      end
    end
  endtask
  task rdc(input [9:0] i, input [7:0] e);
    begin apb(i, 1'b0, 8'h0); chk("rd", e, q); end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_in);
  endtask
  // one-cycle generator pulse, then wait until the flag is registered
  task gpulse(input [5:0] g);
    begin
      gen_in <= g;
      tick(1);
      gen_in <= 6'h2A;
      tick(2);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // clock
  initial
  begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  // watchdog, far beyond the few hundred cycles needed
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    end_sim;
  end
  initial
  begin
    {rst_in, psel_in, penable_in, pwrite_in, cen, adc, trip, glt} = 8'h80;
    paddr_in = 0; pwdata_in = 0; gen_in = 6'h2A; idle = 1;
    pend = 0;
    fail_count = 0; n_tests = 0;
    tick(6); rst_in <= 0;
    // reset values and refusal
    rdc(`POB_IDX_INVERT, 0);
    rdc(`POB_IDX_MASK_EN, 0);
    rdc(`POB_IDX_MASK_LVL, 0); rdc(`POB_IDX_BRAKE, 0); rdc(`POB_IDX_CTRL1, 0);
    apb(10'h001, 1'b0, 8'h0); chk("err", 1, err);
    $display("test reset done");
    // masking then polarity on the path
    apb(`POB_IDX_MASK_EN, 1, 8'hFF); rdc(`POB_IDX_MASK_EN, 8'h3F);
    apb(`POB_IDX_MASK_EN, 1, 8'h0F); apb(`POB_IDX_MASK_LVL, 1, 8'h05);
    apb(`POB_IDX_INVERT, 1, 8'h30); tick(2);
    chk("pwm", ((6'h2A & ~6'h0F) | 6'h05) ^ 6'h30, pwm_out);
    $display("test mask done");
    // centre event only in centre-aligned type
    for (k = 1; k >= 0; k = k - 1)
    begin
      apb(`POB_IDX_CTRL1, 1, k ? 8'h10 : 8'h00); apb(`POB_IDX_EVT_CTRL, 1, 8'h20);
      cen <= 1; tick(1); cen <= 0; tick(1);
      rdc(`POB_IDX_CTRL0, k ? 8'h20 : 8'h00);
      apb(`POB_IDX_CTRL0, 1, 8'h00);
    end
    $display("test event done");
    // edge types on a selected channel, end point, event irq line
    apb(`POB_IDX_IRQ_EN, 1, 8'h02); apb(`POB_IDX_EVT_CTRL, 1, 8'h15);
    gpulse(6'h0A); rdc(`POB_IDX_CTRL0, 8'h20);
    chk("eirq", 1, eirq);
    apb(`POB_IDX_CTRL0, 1, 8'h00); chk("eirq", 0, eirq);
    apb(`POB_IDX_EVT_CTRL, 1, 8'hC6); chk("evc", 8'h06, ec);
    gpulse(6'h0A); rdc(`POB_IDX_CTRL0, 8'h00);
    gpulse(6'h2B); rdc(`POB_IDX_CTRL0, 8'h20);
    apb(`POB_IDX_CTRL0, 1, 8'h00); apb(`POB_IDX_EVT_CTRL, 1, 8'h30);
    for (k = 0; k < 2; k = k + 1)
    begin
      chk("ctl2", k ? 8'h10 : 8'h00, c2);
      pend <= 1; tick(1); pend <= 0; tick(1);
      rdc(`POB_IDX_CTRL0, k ? 8'h20 : 8'h00);
      apb(`POB_IDX_CTRL0, 1, 8'h00); apb(`POB_IDX_CTRL1, 1, 8'h10);
    end
    $display("test edge event done");
    // pin brake: disabled, glitch, real fault, flag clear, resume
    apb(`POB_IDX_CTRL0, 1, 8'h80); trip <= 1; tick(1); trip <= 0; tick(16);
    chk("run", 1, run_out);
    apb(`POB_IDX_BRAKE, 1, 8'h0C); apb(`POB_IDX_CTRL1, 1, 8'h08);
    glt <= 1; tick(1); glt <= 0; tick(16);
    chk("run", 1, run_out);
    trip <= 1; tick(1); trip <= 0; tick(14);
    chk("run", 0, run_out);
    chk("clr", 0, clr);
    chk("pwm", 6'h0C ^ 6'h30, pwm_out);
    rdc(`POB_IDX_BRAKE, 8'h8C);
    apb(`POB_IDX_BRAKE, 1, 8'h0C); rdc(`POB_IDX_BRAKE, 8'h0C);
    chk("pwm", 6'h0C ^ 6'h30, pwm_out);
    apb(`POB_IDX_CTRL0, 1, 8'h80); tick(2);
    chk("pwm", ((6'h2A & ~6'h0F) | 6'h05) ^ 6'h30, pwm_out);
    $display("test pin brake done");
    // rising edge select: falling edge now ignored
    apb(`POB_IDX_BRAKE, 1, 8'h4C); idle <= 0; tick(16);
    chk("run", 1, run_out);
    trip <= 1; tick(1); trip <= 0; tick(14);
    chk("run", 0, run_out);
    $display("test edge done");
    // adc compare event with brake irq enabled
    apb(`POB_IDX_BRAKE, 1, 8'h4C); apb(`POB_IDX_IRQ_EN, 1, 8'h01);
    apb(`POB_IDX_CTRL0, 1, 8'h80); chk("irq", 0, brake_irq_out);
    adc <= 1; tick(1); adc <= 0; tick(1);
    chk("clr", 1, clr);
    tick(1);
    chk("run", 0, run_out);
    chk("irq", 1, brake_irq_out);
    rdc(`POB_IDX_BRAKE, 8'hCC);
    $display("test adc done");
    end_sim;
  end
endmodule // pob_output_stage_tb
